// file: design/crpc_consts.svh
// constants for the clock, reset and power control block
`ifndef CRPC_CONSTS_SVH
`define CRPC_CONSTS_SVH
`define CRPC_ADDR_TC_CTRL 8'hd0
`define CRPC_ADDR_TD_CTRL 8'hd1
`define CRPC_ADDR_TC_RELOAD 8'hd2
`define CRPC_ADDR_TD_RELOAD 8'hd3
`define CRPC_ADDR_CLKDIV 8'hd4
`define CRPC_ADDR_BAUD 8'hd6
`define CRPC_ADDR_STOPGUARD 8'hd7
`define CRPC_ADDR_CNTSEL 8'hd8
`define CRPC_ADDR_SELCNT 8'hda
`define CRPC_ADDR_BT_CTRL 8'hdc
`define CRPC_ADDR_BT_COUNT 8'hdd
`define CRPC_ADDR_SYSMODE 8'hdf
`define CRPC_ADDR_STATUS 8'hc0
`define CRPC_ADDR_CMD 8'hc1
`define CRPC_ADDR_PCVEC 8'hc2
`define CRPC_CLKDIV_LSB 3
`define CRPC_CLKDIV_MASK 8'h99
`define CRPC_CNTSEL_MASK 8'h07
`define CRPC_SYSMODE_MASK 8'h0f
`define CRPC_RST_ZERO 8'h00
`define CRPC_RST_ONES 8'hff
`define CRPC_STOP_KEY 8'ha5
`define CRPC_RESET_VECTOR 16'h0100
`define CRPC_CMD_STOP 0
`define CRPC_CMD_IDLE 1
`define CRPC_CORE_CLK_MHZ 200
`define CRPC_STAB_TIME_US 1000
`define CRPC_STAB_CYCLES (`CRPC_STAB_TIME_US * `CRPC_CORE_CLK_MHZ)
`endif

// file: design/crpc_pkg.sv
// types for the clock, reset and power control block
package crpc_pkg;
    typedef enum logic [1:0] {
        CRPC_ST_STAB,
        CRPC_ST_RUN,
        CRPC_ST_IDLE,
        CRPC_ST_STOP
    } crpc_state_t;
    typedef logic [1:0] crpc_ratio_t;
endpackage

// file: design/crpc_clkdiv.sv
// glitch-free cpu clock enable divider
`timescale 1ns/10ps
`default_nettype none
module crpc_clkdiv
    import crpc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic run,
    input wire crpc_ratio_t ratio,
    output logic tick_ff
);
    typedef struct packed {
        logic [3:0] cnt;
        crpc_ratio_t act;
        logic tick;
    } crpc_div_t;
    crpc_div_t st_ff;
    crpc_div_t nxt_st;
    function automatic logic [3:0] crpc_limit(input crpc_ratio_t r);
        case (r)
            2'b00: crpc_limit = 4'hf;
            2'b01: crpc_limit = 4'h7;
            2'b10: crpc_limit = 4'h1;
            default: crpc_limit = 4'h0;
        endcase
    endfunction
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (run) begin
            // new ratio only adopted at period end so no short pulse appears
            if (st_ff.cnt >= crpc_limit(st_ff.act)) begin
                nxt_st.cnt = 4'h0;
                nxt_st.tick = 1'b1;
                nxt_st.act = ratio;
            end else begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end
    assign tick_ff = st_ff.tick;
endmodule
`default_nettype wire

// file: design/crpc_top.sv
// clock, reset and power-down control with avalon register slave
// Function
// - cpu clock is oscillator divided by 1, 2, 8 or 16.
// - slowest ratio, divide by 16, used until software picks faster.
// - stop mode freezes oscillator, halts everything, retains register contents except the stop guard, cleared on wake.
// - stop exits only on reset or the two wake interrupt lines.
// - idle gates cpu clock; interrupt control and timer keep clocking.
// - idle exits on reset or any interrupt, external or internal.
// - external low reset is synchronised before use.
// - reset returns all control registers to defaults.
// - reset disables interrupts and enables watchdog.
// - reset makes ports 0 to 3 inputs.
// - reset loads pc with vector 0100h; fetch starts after stabilisation.
// - unused or unmapped bits read zero.
// - timer c, timer d reload and baud divisor reset to all ones.
// - basic timer control and count reset to zero.
// - counter select low three bits reset; upper five unused.
// - reset clears divider select bits, selecting divide by 16.
// - stop only with guard key; otherwise pc redirected to reset vector.
`timescale 1ns/10ps
`default_nettype none
`include "crpc_consts.svh"
module crpc_top
    import crpc_pkg::*;
#(
    parameter int STAB_CYCLES = `CRPC_STAB_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic external_reset_low,
    input wire logic [1:0] wake_interrupt_lines,
    input wire logic irq_any,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_run,
    output logic cpu_reset,
    output logic int_disable,
    output logic watchdog_en,
    output logic ports_input,
    output logic [15:0] pc_load_value,
    output logic pc_load,
    output logic [7:0] timer_c_reload,
    output logic [7:0] timer_d_reload,
    output logic [7:0] baud_divisor
);
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] wake_a;
        logic [1:0] wake_b;
        crpc_state_t fsm;
        logic [31:0] stab;
        logic [7:0] tc_ctrl;
        logic [7:0] td_ctrl;
        logic [7:0] tc_rel;
        logic [7:0] td_rel;
        logic [7:0] clkdiv;
        logic [7:0] baud;
        logic [7:0] guard;
        logic [7:0] cntsel;
        logic [7:0] bt_ctrl;
        logic [7:0] bt_count;
        logic [7:0] sysmode;
        logic [31:0] rdata;
        logic ack;
        logic [15:0] pcv;
        logic pcl;
        logic redirect;
        logic stab_lvl;
        logic osc_lvl;
    } crpc_st_t;
    crpc_st_t st_ff;
    crpc_st_t nxt_st;
    logic tick;
    logic bus_req;
    logic wr_hit;
    logic ext_rst;
    logic [1:0] wake_sync;
    assign bus_req = (avs_read | avs_write) & ~st_ff.ack;
    assign wr_hit = avs_write & ~st_ff.ack;
    assign ext_rst = ~st_ff.rst_sync[1];
    assign wake_sync = {st_ff.wake_b[1], st_ff.wake_a[1]};

    crpc_clkdiv u_div (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .run(st_ff.fsm != CRPC_ST_STOP),
        .ratio(st_ff.clkdiv[`CRPC_CLKDIV_LSB +: 2]),
        .tick_ff(tick)
    );

    function automatic logic [7:0] crpc_read(input crpc_st_t s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == `CRPC_ADDR_TC_CTRL) begin
            d = s.tc_ctrl;
        end else if (a == `CRPC_ADDR_TD_CTRL) begin
            d = s.td_ctrl;
        end else if (a == `CRPC_ADDR_TC_RELOAD) begin
            d = s.tc_rel;
        end else if (a == `CRPC_ADDR_TD_RELOAD) begin
            d = s.td_rel;
        end else if (a == `CRPC_ADDR_CLKDIV) begin
            d = s.clkdiv & `CRPC_CLKDIV_MASK;
        end else if (a == `CRPC_ADDR_BAUD) begin
            d = s.baud;
        end else if (a == `CRPC_ADDR_STOPGUARD) begin
            d = s.guard;
        end else if (a == `CRPC_ADDR_CNTSEL) begin
            d = s.cntsel & `CRPC_CNTSEL_MASK;
        end else if (a == `CRPC_ADDR_SELCNT) begin
            // selected counter mirrors basic timer count in this block
            d = s.bt_count;
        end else if (a == `CRPC_ADDR_BT_CTRL) begin
            d = s.bt_ctrl;
        end else if (a == `CRPC_ADDR_BT_COUNT) begin
            d = s.bt_count;
        end else if (a == `CRPC_ADDR_SYSMODE) begin
            d = s.sysmode & `CRPC_SYSMODE_MASK;
        end else if (a == `CRPC_ADDR_STATUS) begin
            d = {4'h0, s.redirect, ext_rst, s.fsm};
        end
        return d;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rst_sync = {st_ff.rst_sync[0], external_reset_low};
        nxt_st.wake_a = {st_ff.wake_a[0], wake_interrupt_lines[0]};
        nxt_st.wake_b = {st_ff.wake_b[0], wake_interrupt_lines[1]};
        nxt_st.pcl = 1'b0;
        nxt_st.ack = bus_req;
        if (avs_read & ~st_ff.ack) begin
            nxt_st.rdata = {24'h0, crpc_read(st_ff, avs_address)};
        end
        if (wr_hit) begin
            if (avs_address == `CRPC_ADDR_TC_CTRL) begin
                nxt_st.tc_ctrl = avs_writedata[7:0];
            end else if (avs_address == `CRPC_ADDR_TD_CTRL) begin
                nxt_st.td_ctrl = avs_writedata[7:0];
            end else if (avs_address == `CRPC_ADDR_TC_RELOAD) begin
                nxt_st.tc_rel = avs_writedata[7:0];
            end else if (avs_address == `CRPC_ADDR_TD_RELOAD) begin
                nxt_st.td_rel = avs_writedata[7:0];
            end else if (avs_address == `CRPC_ADDR_CLKDIV) begin
                nxt_st.clkdiv = avs_writedata[7:0] & `CRPC_CLKDIV_MASK;
            end else if (avs_address == `CRPC_ADDR_BAUD) begin
                nxt_st.baud = avs_writedata[7:0];
            end else if (avs_address == `CRPC_ADDR_STOPGUARD) begin
                nxt_st.guard = avs_writedata[7:0];
            end else if (avs_address == `CRPC_ADDR_CNTSEL) begin
                nxt_st.cntsel = avs_writedata[7:0] & `CRPC_CNTSEL_MASK;
            end else if (avs_address == `CRPC_ADDR_BT_CTRL) begin
                nxt_st.bt_ctrl = avs_writedata[7:0];
            end else if (avs_address == `CRPC_ADDR_BT_COUNT) begin
                nxt_st.bt_count = avs_writedata[7:0];
            end else if (avs_address == `CRPC_ADDR_SYSMODE) begin
                nxt_st.sysmode = avs_writedata[7:0] & `CRPC_SYSMODE_MASK;
            end
        end
        case (st_ff.fsm)
            CRPC_ST_STAB: begin
                if (st_ff.stab >= 32'(STAB_CYCLES - 1)) begin
                    nxt_st.fsm = CRPC_ST_RUN;
                end else begin
                    nxt_st.stab = st_ff.stab + 32'd1;
                end
            end
            CRPC_ST_RUN: begin
                if (wr_hit && avs_address == `CRPC_ADDR_CMD) begin
                    if (avs_writedata[`CRPC_CMD_STOP]) begin
                        if (st_ff.guard == `CRPC_STOP_KEY) begin
                            nxt_st.fsm = CRPC_ST_STOP;
                        end else begin
                            nxt_st.pcv = `CRPC_RESET_VECTOR;
                            nxt_st.pcl = 1'b1;
                            nxt_st.redirect = 1'b1;
                        end
                    end else if (avs_writedata[`CRPC_CMD_IDLE]) begin
                        nxt_st.fsm = CRPC_ST_IDLE;
                    end
                end
            end
            CRPC_ST_IDLE: begin
                if (irq_any | (|wake_sync)) begin
                    nxt_st.fsm = CRPC_ST_RUN;
                end
            end
            default: begin
                // only the filtered wake lines or the external reset restart the oscillator
                if (|wake_sync) begin
                    nxt_st.fsm = CRPC_ST_STAB;
                    nxt_st.stab = 32'd0;
                    nxt_st.guard = `CRPC_RST_ZERO;
                end
            end
        endcase
        if (ext_rst) begin
            nxt_st.fsm = CRPC_ST_STAB;
            nxt_st.stab = 32'd0;
            nxt_st.tc_ctrl = `CRPC_RST_ZERO;
            nxt_st.td_ctrl = `CRPC_RST_ZERO;
            nxt_st.tc_rel = `CRPC_RST_ONES;
            nxt_st.td_rel = `CRPC_RST_ONES;
            nxt_st.baud = `CRPC_RST_ONES;
            nxt_st.clkdiv = `CRPC_RST_ZERO;
            nxt_st.guard = `CRPC_RST_ZERO;
            nxt_st.cntsel = `CRPC_RST_ZERO;
            nxt_st.bt_ctrl = `CRPC_RST_ZERO;
            nxt_st.bt_count = `CRPC_RST_ZERO;
            nxt_st.sysmode = `CRPC_RST_ZERO;
            nxt_st.pcv = `CRPC_RESET_VECTOR;
            nxt_st.pcl = 1'b1;
            nxt_st.redirect = 1'b0;
        end
        // level outputs taken from next state so they leave a flop in step with fsm
        nxt_st.stab_lvl = nxt_st.fsm == CRPC_ST_STAB;
        nxt_st.osc_lvl = nxt_st.fsm != CRPC_ST_STOP;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
            st_ff.rst_sync <= 2'b00;
            st_ff.fsm <= CRPC_ST_STAB;
            st_ff.tc_rel <= `CRPC_RST_ONES;
            st_ff.td_rel <= `CRPC_RST_ONES;
            st_ff.baud <= `CRPC_RST_ONES;
            st_ff.pcv <= `CRPC_RESET_VECTOR;
            st_ff.stab_lvl <= 1'b1;
            st_ff.osc_lvl <= 1'b1;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // registered enables: one cycle behind the divider tick
    logic cpu_en_ff;
    logic per_en_ff;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cpu_en_ff <= 1'b0;
            per_en_ff <= 1'b0;
        end else if (clk_en) begin
            cpu_en_ff <= tick & (st_ff.fsm == CRPC_ST_RUN);
            per_en_ff <= tick & (st_ff.fsm != CRPC_ST_STOP);
        end
    end

    assign avs_readdata = st_ff.rdata;
    assign avs_waitrequest = ~st_ff.ack;
    assign cpu_clk_en = cpu_en_ff;
    assign periph_clk_en = per_en_ff;
    assign osc_run = st_ff.osc_lvl;
    // held through every stabilisation, also after a stop wake
    assign cpu_reset = st_ff.stab_lvl;
    assign int_disable = st_ff.stab_lvl;
    assign watchdog_en = st_ff.stab_lvl;
    assign ports_input = st_ff.stab_lvl;
    assign pc_load_value = st_ff.pcv;
    assign pc_load = st_ff.pcl;
    assign timer_c_reload = st_ff.tc_rel;
    assign timer_d_reload = st_ff.td_rel;
    assign baud_divisor = st_ff.baud;

    a_stab_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && ext_rst) |=> (st_ff.fsm == CRPC_ST_STAB && st_ff.stab == 32'd0))
        else $error("stabilisation not restarted by reset");
    a_stop_key: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && !ext_rst && st_ff.fsm == CRPC_ST_RUN && wr_hit
         && avs_address == `CRPC_ADDR_CMD && avs_writedata[0]
         && st_ff.guard != `CRPC_STOP_KEY) |=> (pc_load && st_ff.fsm != CRPC_ST_STOP))
        else $error("stop taken without key");
    a_reset_ones: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && ext_rst) |=> (timer_c_reload == 8'hff && baud_divisor == 8'hff))
        else $error("reload registers not set to ones");
    a_reset_div: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && ext_rst) |=> (st_ff.clkdiv == 8'h00))
        else $error("divider select not cleared");
    a_stop_freeze: assert property (@(posedge core_clk) disable iff (sys_rst)
        (st_ff.fsm == CRPC_ST_STOP) |-> ##1 (!cpu_clk_en && !periph_clk_en))
        else $error("clock runs in stop");
    a_idle_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        (st_ff.fsm == CRPC_ST_IDLE && $past(st_ff.fsm) == CRPC_ST_IDLE) |-> !cpu_clk_en)
        else $error("cpu clocked in idle");
    a_idle_exit: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && st_ff.fsm == CRPC_ST_IDLE && irq_any) |=> (st_ff.fsm != CRPC_ST_IDLE))
        else $error("idle not left on interrupt");
    a_bus_answer: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && avs_read && !st_ff.ack && avs_address == 8'hdb) |=> (avs_readdata == 32'h0))
        else $error("unmapped read not zero");
    a_stop_stay: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clk_en && st_ff.fsm == CRPC_ST_STOP && !ext_rst && wake_sync == 2'b00)
        |=> (st_ff.fsm == CRPC_ST_STOP))
        else $error("stop left without wake or reset");
    sequence s_stop_wake;
        (clk_en && st_ff.fsm == CRPC_ST_STOP && !ext_rst && wake_sync != 2'b00)
        ##1 (st_ff.fsm == CRPC_ST_STAB);
    endsequence
    a_wake_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_stop_wake |-> (cpu_reset && !cpu_clk_en))
        else $error("cpu not held after stop wake");
endmodule
`default_nettype wire

// file: tb/crpc_board_model.sv
// board model: power-on reset source and wake interrupt pins
`timescale 1ns/10ps
`default_nettype none
module crpc_board_model #(
    parameter int POR_HOLD = 30
) (
    input wire logic core_clk,
    input wire logic rst_req,
    input wire logic [1:0] wake_req,
    output logic external_reset_low,
    output logic [1:0] wake_interrupt_lines
);
    int por_cnt;
    initial begin
        por_cnt = 0;
        external_reset_low = 1'b0;
        wake_interrupt_lines = 2'b00;
    end
    always @(posedge core_clk) begin
        if (por_cnt < POR_HOLD) begin
            por_cnt <= por_cnt + 1;
        end
        // test pin taken as grounded: only on-chip rom mode exists here
        // pin stays low after power-up so the oscillator settles
        external_reset_low <= (por_cnt >= POR_HOLD) && !rst_req;
        // pins change only on the clock edge, like a filtered input
        wake_interrupt_lines <= wake_req;
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the clock, reset and power control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import crpc_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic irq_any = 1'b0;
    logic rst_req = 1'b0;
    logic [1:0] wake_req = 2'b00;
    logic external_reset_low;
    logic [1:0] wake_interrupt_lines;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, cpu_clk_en, periph_clk_en, osc_run, cpu_reset;
    logic int_disable, watchdog_en, ports_input, pc_load;
    logic [15:0] pc_load_value;
    logic [7:0] timer_c_reload, timer_d_reload, baud_divisor;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int cpu_n = 0;
    int per_n = 0;
    int pc_n = 0;
    int a, b, p;
    logic [31:0] q;
    logic [7:0] rst_addr [11] = '{8'hdc, 8'hdd, 8'hd8, 8'hd4, 8'hd7, 8'hd2, 8'hd3,
        8'hd6, 8'hdb, 8'hde, 8'hc2};
    logic [7:0] rst_exp [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
        8'hff, 8'h00, 8'h00, 8'h00};
    int div_exp [4] = '{16, 8, 2, 1};

    crpc_top #(.STAB_CYCLES(20)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .external_reset_low(external_reset_low),
        .wake_interrupt_lines(wake_interrupt_lines), .irq_any(irq_any),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .osc_run(osc_run), .cpu_reset(cpu_reset),
        .int_disable(int_disable), .watchdog_en(watchdog_en),
        .ports_input(ports_input), .pc_load_value(pc_load_value), .pc_load(pc_load),
        .timer_c_reload(timer_c_reload), .timer_d_reload(timer_d_reload),
        .baud_divisor(baud_divisor));
    crpc_board_model #(.POR_HOLD(30)) board (.core_clk(core_clk), .rst_req(rst_req),
        .wake_req(wake_req), .external_reset_low(external_reset_low),
        .wake_interrupt_lines(wake_interrupt_lines));

    always #2.5 core_clk = ~core_clk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // pulse counters let a test compare activity over a window
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        cpu_n <= cpu_n + int'(cpu_clk_en === 1'b1);
        per_n <= per_n + int'(periph_clk_en === 1'b1);
        pc_n <= pc_n + int'(pc_load === 1'b1);
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [7:0] d,
        output logic [31:0] rd);
        @(posedge core_clk);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, adr, d, x);
    endtask

    task automatic rd(input string name, input logic [7:0] adr, input logic [7:0] m,
        input logic [7:0] exp);
        logic [31:0] x;
        bus(1'b0, adr, 8'h00, x);
        check(name, x & {24'h0, m}, {24'h0, exp});
    endtask

    // cycles between two cpu clock pulses, bounded
    task automatic period(output int n);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (cpu_clk_en !== 1'b1 && n < 40);
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        repeat (6) @(posedge core_clk);
        while (cpu_reset !== 1'b0 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        rd("state run", 8'hc0, 8'h03, 8'h01);
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        check("cpu_reset", cpu_reset, 1'b1);
        check("irq wdog ports", {int_disable, watchdog_en, ports_input}, 3'b111);
        check("pc vector", pc_load_value, 16'h0100);
        check("reload outs", {timer_c_reload, timer_d_reload, baud_divisor}, 24'hffffff);
        for (int i = 0; i < 11; i++) begin
            rd("reset value", rst_addr[i], 8'hff, rst_exp[i]);
        end
        wait_run();
        $display("test reset values done");
        period(p);
        check("default ratio", p, 16);
        wr(8'hd4, 8'hff);
        rd("divider mask", 8'hd4, 8'hff, 8'h99);
        for (int r = 0; r < 4; r++) begin
            wr(8'hd4, 8'(r << 3));
            period(p);
            period(p);
            check("divide ratio", p, div_exp[r]);
        end
        $display("test divider done");
        wr(8'hd2, 8'h5a);
        wr(8'hd7, 8'ha5);
        wr(8'hc1, 8'h01);
        repeat (4) @(posedge core_clk);
        rd("state stop", 8'hc0, 8'h03, 8'h03);
        check("osc frozen", osc_run, 1'b0);
        a = cpu_n;
        b = per_n;
        irq_any <= 1'b1;
        repeat (32) @(posedge core_clk);
        check("no cpu clock in stop", cpu_n - a, 0);
        check("no periph clock in stop", per_n - b, 0);
        rd("irq does not wake", 8'hc0, 8'h03, 8'h03);
        irq_any <= 1'b0;
        wake_req <= 2'b10;
        wait_run();
        wake_req <= 2'b00;
        rd("guard cleared", 8'hd7, 8'hff, 8'h00);
        rd("data kept", 8'hd2, 8'hff, 8'h5a);
        rd("ratio kept", 8'hd4, 8'h18, 8'h18);
        $display("test stop done");
        wr(8'hc1, 8'h02);
        repeat (4) @(posedge core_clk);
        rd("state idle", 8'hc0, 8'h03, 8'h02);
        a = cpu_n;
        b = per_n;
        repeat (32) @(posedge core_clk);
        check("cpu gated", cpu_n - a, 0);
        check("periph running", (per_n - b) > 0, 1'b1);
        irq_any <= 1'b1;
        repeat (4) @(posedge core_clk);
        irq_any <= 1'b0;
        rd("idle wake", 8'hc0, 8'h03, 8'h01);
        $display("test idle done");
        a = pc_n;
        wr(8'hc1, 8'h01);
        repeat (4) @(posedge core_clk);
        check("redirect pulse", pc_n - a, 1);
        check("redirect vector", pc_load_value, 16'h0100);
        rd("no stop no reset", 8'hc0, 8'h0b, 8'h09);
        $display("test guard done");
        rst_req <= 1'b1;
        repeat (10) @(posedge core_clk);
        check("pin reset", {cpu_reset, ports_input, int_disable}, 3'b111);
        rd("divider default", 8'hd4, 8'hff, 8'h00);
        rd("reload default", 8'hd2, 8'hff, 8'hff);
        rst_req <= 1'b0;
        wait_run();
        period(p);
        check("slow after reset", p, 16);
        $display("test pin reset done");
        conclude();
    end
endmodule
`default_nettype wire
